/* logic/strp_defs.svh */
// Constants for the serial register port: addresses, fields, timing.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef STRP_DEFS_SVH
`define STRP_DEFS_SVH

// Serial frame layout
`define STRP_ADDR_W 7
`define STRP_RW_WRITE 1'b1
`define STRP_FRAME_1B 6'd16
`define STRP_FRAME_2B 6'd24
`define STRP_FRAME_3B 6'd32
`define STRP_ADDR_BITS 6'd7
`define STRP_CNT_MAX 6'h3F

// Device register addresses
`define STRP_GLOBAL_ADDR 7'h50
`define STRP_STATUS_ADDR 7'h51
`define STRP_MASK_ADDR 7'h52
`define STRP_MEM_DEPTH 128

// Device status fields
`define STRP_ST_FRAME_ERR 0
`define STRP_ST_WRITE_DONE 1
`define STRP_ST_W 2
`define STRP_GI_SUMMARY 7

// Host register offsets (byte addresses)
`define STRP_H_CTRL 8'h00
`define STRP_H_ADDR 8'h04
`define STRP_H_WDATA 8'h08
`define STRP_H_RDATA 8'h0C
`define STRP_H_STATUS 8'h10
`define STRP_H_MASK 8'h14

// Host control and status fields
`define STRP_C_START 0
`define STRP_C_READ 1
`define STRP_C_CLK_LO 8
`define STRP_C_CLK_HI 13
`define STRP_S_BUSY 0
`define STRP_S_DONE 1

// Timing
`define STRP_CLK_NS 20
`define STRP_HALF_CYC 7'd8
`define STRP_GAP_NS 2000
`define STRP_GAP_CYC ((`STRP_GAP_NS + `STRP_CLK_NS - 1) / `STRP_CLK_NS)

`endif

/* logic/strp_device.sv */
// Target end of the serial register port with its register array.
// Assumes the link pins are asynchronous to pclk and sclk is far slower.
//
// What this block does
// - Sample input on rise, change output on fall
// - Controller sends address, direction, one-three bytes
// - Write frame needs sixteen clocks minimum
// - Burst write stores bytes at consecutive addresses
// - Commit writes only on deselect after count
// - Thirty-one clocks commit two bytes, drop third
// - Wrong clock count sets frame error flag
// - Output released while select is high
// - Select fall drives global interrupt bit seven
// - Global interrupt byte first; writes return nothing else
// - Reads return one-three bytes after global byte
// - Controller waits two microseconds after write
// - Controller holds select low whole frame
// - Address increments for each further byte
`timescale 1ns/1ps
`default_nettype none
`include "strp_defs.svh"
module strp_device import strp_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Serial link
	strp_if.dev link,
	// User side
	output logic irq_r,
	output logic serial_frame_error_flag_r
);
	logic [2:0] pin_q;
	logic [2:0] pin_rise;
	logic [2:0] pin_fall;
	logic sclk_rise;
	logic sclk_fall;
	logic sel_fall;
	logic sel_rise;
	logic sdi;
	logic active_r;
	logic [5:0] bit_cnt_r;
	logic [6:0] in_sh_r;
	logic [6:0] addr_r;
	logic rw_r;
	strp_byte_type wbuf_r [0:2];
	strp_byte_type out_sh_r;
	strp_byte_type mem [0:`STRP_MEM_DEPTH-1];
	logic [`STRP_ST_W-1:0] status_r;
	logic [`STRP_ST_W-1:0] mask_r;
	logic [`STRP_ST_W-1:0] status_set;
	logic [`STRP_ST_W-1:0] status_clr;
	logic mask_wr;
	strp_byte_type mask_val;
	logic [1:0] nbytes;
	logic commit_en;
	logic frame_bad;
	strp_byte_type gi;
	strp_byte_type next_byte;

	// Bit 0 sclk, bit 1 select (idles high), bit 2 serial input
	strp_sync #(.W(3), .INIT(3'b010)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({link.ser_in, link.select_low_pin, link.sclk}),
		.q(pin_q),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	assign sdi = pin_q[2];
	assign sel_fall = pin_fall[1];
	assign sel_rise = pin_rise[1] & active_r;
	// Clock edges count only while selected
	assign sclk_rise = pin_rise[0] & active_r & ~pin_q[1];
	assign sclk_fall = pin_fall[0] & active_r & ~pin_q[1];

	// Registers at 7'h50..7'h52 are live state, the rest plain storage
	function automatic strp_byte_type rd_byte(input logic [6:0] a);
		if (a == `STRP_GLOBAL_ADDR)
			rd_byte = gi;
		else if (a == `STRP_STATUS_ADDR)
			rd_byte = {6'h00, status_r};
		else if (a == `STRP_MASK_ADDR)
			rd_byte = {6'h00, mask_r};
		else
			rd_byte = mem[a];
	endfunction

	function automatic logic is_live(input logic [6:0] a);
		is_live = (a == `STRP_GLOBAL_ADDR) || (a == `STRP_STATUS_ADDR) ||
			(a == `STRP_MASK_ADDR);
	endfunction

	assign gi = {|(status_r & ~mask_r), 5'h00, status_r};

	// Complete bytes only; an over-long frame commits nothing
	always_comb begin
		if (bit_cnt_r >= `STRP_FRAME_1B && bit_cnt_r < `STRP_FRAME_2B)
			nbytes = 2'd1;
		else if (bit_cnt_r >= `STRP_FRAME_2B && bit_cnt_r < `STRP_FRAME_3B)
			nbytes = 2'd2;
		else if (bit_cnt_r == `STRP_FRAME_3B)
			nbytes = 2'd3;
		else
			nbytes = 2'd0;
	end

	assign commit_en = sel_rise & (rw_r == `STRP_RW_WRITE) &
		(nbytes != 2'd0);
	assign frame_bad = (bit_cnt_r != `STRP_FRAME_1B) &&
		(bit_cnt_r != `STRP_FRAME_2B) && (bit_cnt_r != `STRP_FRAME_3B);

	// Byte for the next output slot; zeros past the read data
	always_comb begin
		next_byte = 8'h00;
		if (rw_r != `STRP_RW_WRITE && bit_cnt_r <= `STRP_FRAME_2B)
			next_byte = rd_byte(addr_r + 7'(bit_cnt_r[4:3] - 2'd1));
	end

	// Writes that land on the live registers
	always_comb begin
		status_clr = '0;
		mask_wr = 1'b0;
		mask_val = {6'h00, mask_r};
		for (int i = 0; i < 3; i++) begin
			if (commit_en && 2'(i) < nbytes) begin
				if (addr_r + 7'(i) == `STRP_STATUS_ADDR)
					status_clr = status_clr | wbuf_r[i][`STRP_ST_W-1:0];
				if (addr_r + 7'(i) == `STRP_MASK_ADDR) begin
					mask_wr = 1'b1;
					mask_val = wbuf_r[i];
				end
			end
		end
	end

	always_comb begin
		status_set = '0;
		status_set[`STRP_ST_FRAME_ERR] = sel_rise & frame_bad;
		status_set[`STRP_ST_WRITE_DONE] = commit_en;
	end

	// Frame receive: select framing, bit count, input shifter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_r <= 1'b0;
			bit_cnt_r <= 6'd0;
			in_sh_r <= 7'h00;
			addr_r <= 7'h00;
			rw_r <= `STRP_RW_WRITE;
		end else if (sel_fall) begin
			active_r <= 1'b1;
			bit_cnt_r <= 6'd0;
		end else if (sel_rise) begin
			active_r <= 1'b0;
		end else if (sclk_rise) begin
			if (bit_cnt_r != `STRP_CNT_MAX)
				bit_cnt_r <= bit_cnt_r + 6'd1;
			in_sh_r <= {in_sh_r[5:0], sdi};
			if (bit_cnt_r == `STRP_ADDR_BITS) begin
				addr_r <= in_sh_r;
				rw_r <= sdi;
			end
		end
	end

	// Data bytes held until deselect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 3; i++)
				wbuf_r[i] <= 8'h00;
		end else if (sclk_rise && bit_cnt_r[2:0] == 3'd7 &&
				bit_cnt_r >= 6'd15 && bit_cnt_r <= 6'd31) begin
			wbuf_r[bit_cnt_r[4:3] - 2'd1] <= {in_sh_r, sdi};
		end
	end

	// Serial output: global byte first, read data after
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_sh_r <= 8'h00;
			link.ser_out <= 1'b0;
			link.ser_out_oe <= 1'b0;
		end else if (sel_fall) begin
			out_sh_r <= gi;
			link.ser_out <= gi[`STRP_GI_SUMMARY];
			link.ser_out_oe <= 1'b1;
		end else if (sel_rise) begin
			link.ser_out_oe <= 1'b0;
		end else if (sclk_fall) begin
			if (bit_cnt_r[2:0] == 3'd0 && bit_cnt_r != 6'd0) begin
				out_sh_r <= next_byte;
				link.ser_out <= next_byte[7];
			end else begin
				out_sh_r <= {out_sh_r[6:0], 1'b0};
				link.ser_out <= out_sh_r[6];
			end
		end
	end

	// Plain storage; the live registers are kept elsewhere
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int a = 0; a < `STRP_MEM_DEPTH; a++)
				mem[a] <= 8'h00;
		end else if (commit_en) begin
			for (int i = 0; i < 3; i++) begin
				if (2'(i) < nbytes && !is_live(addr_r + 7'(i)))
					mem[addr_r + 7'(i)] <= wbuf_r[i];
			end
		end
	end

	// Sticky events; a set in the clearing cycle survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status_r <= '0;
		else
			status_r <= (status_r & ~status_clr) | status_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mask_r <= '0;
		else if (mask_wr)
			mask_r <= mask_val[`STRP_ST_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
			serial_frame_error_flag_r <= 1'b0;
		end else begin
			irq_r <= |(status_r & ~mask_r);
			serial_frame_error_flag_r <= status_r[`STRP_ST_FRAME_ERR];
		end
	end
endmodule
`default_nettype wire

/* logic/strp_host.sv */
// Controller end: APB slave registers drive serial frames to the target.
// Assumes an APB master on pclk and the target on the far link.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "strp_defs.svh"
module strp_host import strp_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_r,
	output logic pready_r,
	output logic pslverr_r,
	// Interrupt
	output logic irq_r,
	// Serial link
	strp_if.host link
);
	strp_host_state_type state_r;
	logic [6:0] timer_r;
	logic [5:0] bits_left_r;
	logic [31:0] tx_r;
	logic [31:0] rx_r;
	logic [31:0] rdata_r;
	logic [5:0] clk_cnt_r;
	logic read_r;
	logic [6:0] addr_r;
	logic [23:0] wdata_r;
	logic done_r;
	logic done_mask_r;
	logic sclk_r;
	logic sel_n_r;
	logic sdi_r;
	logic sdo_q;
	logic wr_en;
	logic start;
	logic busy;

	strp_sync #(.W(1), .INIT(1'b1)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(link.ser_out_line),
		.q(sdo_q),
		.rise(),
		.fall()
	);

	assign link.sclk = sclk_r;
	assign link.select_low_pin = sel_n_r;
	assign link.ser_in = sdi_r;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `STRP_H_CTRL) || (a == `STRP_H_ADDR) ||
			(a == `STRP_H_WDATA) || (a == `STRP_H_RDATA) ||
			(a == `STRP_H_STATUS) || (a == `STRP_H_MASK);
	endfunction

	assign busy = (state_r != H_IDLE);
	assign wr_en = psel & penable & pready_r & pwrite;
	// Start while busy or in the gap is ignored
	assign start = wr_en & (paddr == `STRP_H_CTRL) &
		pwdata[`STRP_C_START] & ~busy;

	// APB: one wait-free access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= psel & ~penable;
			pslverr_r <= psel & ~penable & ~mapped(paddr);
			prdata_r <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`STRP_H_CTRL: prdata_r <= {18'h00000, clk_cnt_r, 6'h00,
						read_r, 1'b0};
					`STRP_H_ADDR: prdata_r <= {25'h0000000, addr_r};
					`STRP_H_WDATA: prdata_r <= {8'h00, wdata_r};
					`STRP_H_RDATA: prdata_r <= rdata_r;
					`STRP_H_STATUS: prdata_r <= {30'h00000000, done_r, busy};
					`STRP_H_MASK: prdata_r <= {30'h00000000, done_mask_r,
						1'b0};
					default: prdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_cnt_r <= `STRP_FRAME_1B;
			read_r <= 1'b0;
			addr_r <= 7'h00;
			wdata_r <= 24'h000000;
			done_mask_r <= 1'b0;
		end else if (wr_en) begin
			case (paddr)
				`STRP_H_CTRL: begin
					if (!busy) begin
						clk_cnt_r <= pwdata[`STRP_C_CLK_HI:`STRP_C_CLK_LO];
						read_r <= pwdata[`STRP_C_READ];
					end
				end
				`STRP_H_ADDR: addr_r <= pwdata[6:0];
				`STRP_H_WDATA: wdata_r <= pwdata[23:0];
				`STRP_H_MASK: done_mask_r <= pwdata[`STRP_S_DONE];
				default: ;
			endcase
		end
	end

	// Frame sequencer; sclk half period of eight pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= H_IDLE;
			timer_r <= 7'd0;
			bits_left_r <= 6'd0;
			tx_r <= 32'h0000_0000;
			rx_r <= 32'h0000_0000;
			sclk_r <= 1'b0;
			sel_n_r <= 1'b1;
			sdi_r <= 1'b0;
		end else begin
			if (timer_r != 7'd0)
				timer_r <= timer_r - 7'd1;
			case (state_r)
				H_IDLE: begin
					if (start) begin
						tx_r <= {addr_r, (pwdata[`STRP_C_READ] ?
							~`STRP_RW_WRITE : `STRP_RW_WRITE), wdata_r};
						bits_left_r <= pwdata[`STRP_C_CLK_HI:`STRP_C_CLK_LO];
						rx_r <= 32'h0000_0000;
						sel_n_r <= 1'b0;
						timer_r <= `STRP_HALF_CYC - 7'd1;
						state_r <= H_LEAD;
					end
				end
				H_LEAD: begin
					if (timer_r == 7'd0) begin
						timer_r <= `STRP_HALF_CYC - 7'd1;
						if (bits_left_r == 6'd0) begin
							state_r <= H_TAIL;
						end else begin
							sdi_r <= tx_r[31];
							tx_r <= {tx_r[30:0], 1'b0};
							state_r <= H_LOW;
						end
					end
				end
				H_LOW: begin
					if (timer_r == 7'd0) begin
						sclk_r <= 1'b1;
						timer_r <= `STRP_HALF_CYC - 7'd1;
						state_r <= H_HIGH;
					end
				end
				H_HIGH: begin
					if (timer_r == 7'd0) begin
						// Late in the high phase, after the target has settled
						rx_r <= {rx_r[30:0], sdo_q};
						sclk_r <= 1'b0;
						bits_left_r <= bits_left_r - 6'd1;
						timer_r <= `STRP_HALF_CYC - 7'd1;
						if (bits_left_r == 6'd1) begin
							state_r <= H_TAIL;
						end else begin
							sdi_r <= tx_r[31];
							tx_r <= {tx_r[30:0], 1'b0};
							state_r <= H_LOW;
						end
					end
				end
				H_TAIL: begin
					if (timer_r == 7'd0) begin
						sel_n_r <= 1'b1;
						timer_r <= 7'(`STRP_GAP_CYC - 1);
						state_r <= H_GAP;
					end
				end
				H_GAP: begin
					if (timer_r == 7'd0)
						state_r <= H_IDLE;
				end
				default: state_r <= H_IDLE;
			endcase
		end
	end

	// Result and sticky done; set wins over a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_r <= 32'h0000_0000;
			done_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			if (state_r == H_TAIL && timer_r == 7'd0) begin
				rdata_r <= rx_r;
				done_r <= 1'b1;
			end else if (wr_en && paddr == `STRP_H_STATUS &&
					pwdata[`STRP_S_DONE]) begin
				done_r <= 1'b0;
			end
			irq_r <= done_r & done_mask_r;
		end
	end
endmodule
`default_nettype wire

/* logic/strp_if.sv */
// Serial link between controller and target.
// Assumes a pull-up on the target output line when it is not driven.
`timescale 1ns/1ps
`default_nettype none
interface strp_if;
	logic sclk;
	logic select_low_pin;
	logic ser_in;
	logic ser_out;
	logic ser_out_oe;
	logic ser_out_line;

	// Released line reads high through the pull-up
	assign ser_out_line = ser_out_oe ? ser_out : 1'b1;

	modport dev (
		input sclk,
		input select_low_pin,
		input ser_in,
		output ser_out,
		output ser_out_oe
	);
	modport host (
		output sclk,
		output select_low_pin,
		output ser_in,
		input ser_out_line
	);
endinterface
`default_nettype wire

/* logic/strp_pkg.sv */
// Types shared by both ends of the serial register port.
// Assumes strp_defs.svh holds the numeric constants.
package strp_pkg;
	typedef logic [7:0] strp_byte_type;
	typedef enum logic [2:0] {
		H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL, H_GAP
	} strp_host_state_type;
endpackage

/* logic/strp_sync.sv */
// Two-stage synchroniser with edge detection for link pins.
// Assumes inputs asynchronous to pclk; edges lag the pin by two clocks.
`timescale 1ns/1ps
`default_nettype none
module strp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins and results
	input wire logic [W-1:0] d,
	output logic [W-1:0] q,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_r;
			logic s2_r;
			logic s3_r;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_r <= INIT[i];
					s2_r <= INIT[i];
					s3_r <= INIT[i];
				end else begin
					s1_r <= d[i];
					s2_r <= s1_r;
					s3_r <= s2_r;
				end
			end
			assign q[i] = s2_r;
			assign rise[i] = s2_r & ~s3_r;
			assign fall[i] = ~s2_r & s3_r;
		end
	endgenerate
endmodule
`default_nettype wire

/* verification/strp_link_asserts.sv */
// Concurrent checks on the serial link between controller and target.
// Assumes the link signals, pclk and presetn arrive as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module strp_link_asserts (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Serial link
	input wire logic sclk,
	input wire logic select_low_pin,
	input wire logic ser_in,
	input wire logic ser_out,
	input wire logic ser_out_oe
);
	logic [6:0] gap_cnt_r;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Saturates, so the first frame after reset is never flagged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			gap_cnt_r <= 7'h7F;
		else if (!select_low_pin)
			gap_cnt_r <= 7'h00;
		else if (gap_cnt_r != 7'h7F)
			gap_cnt_r <= gap_cnt_r + 7'h01;
	end

	property p_oe_idle;
		select_low_pin [*6] |-> !ser_out_oe;
	endproperty
	a_oe_idle: assert property (p_oe_idle)
		else $error("target drives while deselected");

	property p_oe_on;
		$fell(select_low_pin) |-> ##[2:6] ser_out_oe;
	endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("target output not driven after select");

	property p_release;
		$rose(select_low_pin) |-> !sclk ##[2:6] !ser_out_oe;
	endproperty
	a_release: assert property (p_release)
		else $error("output not released after deselect");

	property p_in_edge;
		$changed(ser_in) |-> !sclk;
	endproperty
	a_in_edge: assert property (p_in_edge)
		else $error("input data changed while clock high");

	property p_out_edge;
		$changed(ser_out) && ser_out_oe && $past(ser_out_oe) |->
			!sclk && !$past(sclk);
	endproperty
	a_out_edge: assert property (p_out_edge)
		else $error("output data changed off falling clock");

	property p_sclk_high;
		$rose(sclk) |-> sclk [*8] ##1 !sclk;
	endproperty
	a_sclk_high: assert property (p_sclk_high)
		else $error("serial clock high time wrong");

	property p_sclk_sel;
		$rose(sclk) |-> !select_low_pin;
	endproperty
	a_sclk_sel: assert property (p_sclk_sel)
		else $error("serial clock outside frame");

	property p_sel_hold;
		$fell(select_low_pin) |-> !select_low_pin [*8];
	endproperty
	a_sel_hold: assert property (p_sel_hold)
		else $error("select released early");

	property p_gap;
		$fell(select_low_pin) |-> $past(gap_cnt_r) >= 7'h64;
	endproperty
	a_gap: assert property (p_gap)
		else $error("frames closer than the gap");
endmodule
`default_nettype wire

/* verification/tb.sv */
// Bench: APB drives the controller end, which talks to the target end.
// Assumes the design files and strp_defs.svh are on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "strp_defs.svh"
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin \
	fail_count++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module tb;
	logic pclk, presetn, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata_r, r;
	logic pready_r, pslverr_r, host_irq, dev_irq, err_flag, e;
	int fail_count, comparisons;

	strp_if lnk();
	strp_host strp_host_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
		.irq_r(host_irq), .link(lnk));
	strp_device strp_device_i (.pclk(pclk), .presetn(presetn), .link(lnk),
		.irq_r(dev_irq), .serial_frame_error_flag_r(err_flag));
	strp_link_asserts strp_link_asserts_i (.pclk(pclk), .presetn(presetn),
		.sclk(lnk.sclk), .select_low_pin(lnk.select_low_pin),
		.ser_in(lnk.ser_in), .ser_out(lnk.ser_out),
		.ser_out_oe(lnk.ser_out_oe));

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready_r !== 1'b1);
		`CHK("pready", 1'b1, pready_r)
		r = prdata_r;
		e = pslverr_r;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Waits on busy, which also covers the enforced inter-frame gap
	task automatic frame(input logic [6:0] a, input logic rdf,
		input logic [5:0] n, input logic [23:0] wd);
		int i;
		apb(1'b1, `STRP_H_ADDR, {25'h0, a});
		apb(1'b1, `STRP_H_WDATA, {8'h00, wd});
		apb(1'b1, `STRP_H_CTRL, {18'h0, n, 6'h00, rdf, 1'b1});
		apb(1'b0, `STRP_H_STATUS, 32'h0);
		`CHK("busy", 1'b1, r[0])
		i = 0;
		while (r[0] === 1'b1 && i < 400) begin
			apb(1'b0, `STRP_H_STATUS, 32'h0);
			i++;
		end
		`CHK("idle", 1'b0, r[0])
		apb(1'b0, `STRP_H_RDATA, 32'h0);
	endtask

	task automatic t_regs;
		apb(1'b0, `STRP_H_CTRL, 32'h0);
		`CHK("ctrl reset", 32'h0000_1000, r)
		apb(1'b0, `STRP_H_MASK, 32'h0);
		`CHK("mask reset", 32'h0, r)
		apb(1'b0, 8'h20, 32'h0);
		`CHK("unmapped err", 1'b1, e)
		`CHK("unmapped data", 32'h0, r)
		$display("test regs done");
	endtask

	task automatic t_burst;
		frame(7'h10, 1'b0, 6'd32, 24'hA1B2C3);
		`CHK("write reply", 32'h0, r)
		`CHK("no error", 1'b0, err_flag)
		`CHK("host irq masked", 1'b0, host_irq)
		frame(7'h10, 1'b1, 6'd32, 24'h0);
		`CHK("burst read", 32'h82A1_B2C3, r)
		$display("test burst done");
	endtask

	task automatic t_short;
		frame(7'h20, 1'b0, 6'd31, 24'h112233);
		`CHK("frame error", 1'b1, err_flag)
		frame(7'h20, 1'b1, 6'd32, 24'h0);
		`CHK("two bytes kept", 32'h8311_2200, r)
		$display("test short done");
	endtask

	task automatic t_single;
		frame(7'h30, 1'b0, 6'd16, 24'h5A0000);
		frame(7'h30, 1'b1, 6'd16, 24'h0);
		`CHK("single read", 16'h835A, r[15:0])
		frame(7'h50, 1'b0, 6'd16, 24'hFF0000);
		frame(7'h50, 1'b1, 6'd16, 24'h0);
		`CHK("global ro", 16'h8383, r[15:0])
		$display("test single done");
	endtask

	task automatic t_dev_irq;
		frame(7'h52, 1'b0, 6'd16, 24'h010000);
		`CHK("dev irq set", 1'b1, dev_irq)
		frame(7'h50, 1'b1, 6'd16, 24'h0);
		`CHK("global bit7", 16'h8383, r[15:0])
		// The clearing write sets write-done again; set wins
		frame(7'h51, 1'b0, 6'd16, 24'h030000);
		`CHK("dev irq done again", 1'b1, dev_irq)
		`CHK("error cleared", 1'b0, err_flag)
		frame(7'h52, 1'b0, 6'd16, 24'h030000);
		`CHK("dev irq masked", 1'b0, dev_irq)
		frame(7'h51, 1'b1, 6'd16, 24'h0);
		`CHK("status w1c", 16'h0202, r[15:0])
		$display("test device irq done");
	endtask

	task automatic t_host_irq;
		apb(1'b1, `STRP_H_STATUS, 32'h2);
		apb(1'b1, `STRP_H_MASK, 32'h2);
		`CHK("host irq idle", 1'b0, host_irq)
		frame(7'h10, 1'b1, 6'd24, 24'h0);
		`CHK("read two", 16'hA1B2, r[15:0])
		`CHK("host irq set", 1'b1, host_irq)
		apb(1'b1, `STRP_H_STATUS, 32'h2);
		apb(1'b0, `STRP_H_STATUS, 32'h0);
		`CHK("done cleared", 1'b0, r[1])
		`CHK("host irq clear", 1'b0, host_irq)
		$display("test host irq done");
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// Whole run needs roughly 130 us
	initial begin
		#1000000;
		fail_count++;
		final_report;
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fail_count = 0;
		comparisons = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_burst;
		t_short;
		t_single;
		t_dev_irq;
		t_host_irq;
		final_report;
	end
endmodule
`default_nettype wire
